// [logic/fim_monitor.sv]
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fim_monitor (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        faultInputA,
    input  wire logic        faultInputB,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    output logic             failsafeOutputN,
    output logic             resetOutputN,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]  settings;
        logic        phase;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic [31:0] rdata;
        logic        failsafeN;
        logic        resetN;
        logic        irq;
    } fim_state_s;

    fim_state_s state;
    fim_state_s next_state;
    logic [1:0] syncIn;
    logic       inA;
    logic       inB;
    logic [1:0] cfg;
    logic       faultPair;
    logic       faultA;
    logic       faultB;
    logic       wantFs;
    logic       wantRst;
    logic       lockedWrite;

    fim_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .nrst   (nrst),
        .asyncIn({faultInputB, faultInputA}),
        .syncOut(syncIn)
    );

    assign inA = syncIn[0];
    assign inB = syncIn[1];
    assign cfg = state.settings[fim_pkg::CFG_LSB +: 2];

    always_comb
    begin
        faultPair = 1'b0;
        faultA    = 1'b0;
        faultB    = 1'b0;
        unique case (fim_pkg::fim_cfg_e'(cfg))
            fim_pkg::FIM_CFG_OFF:
            begin
                faultPair = 1'b0;
            end
            fim_pkg::FIM_CFG_PAIR:
            begin
                // complementary pair: any deviation from the healthy pattern faults
                if (state.settings[fim_pkg::POL_PAIR_BIT])
                    faultPair = inA | ~inB;
                else
                    faultPair = ~inA | inB;
            end
            fim_pkg::FIM_CFG_INDEP:
            begin
                faultA = inA ~^ state.settings[fim_pkg::POL_A_BIT];
                faultB = inB ~^ state.settings[fim_pkg::POL_B_BIT];
            end
            fim_pkg::FIM_CFG_AONLY:
            begin
                faultA = inA ~^ state.settings[fim_pkg::POL_A_BIT];
            end
        endcase
    end

    always_comb
    begin
        wantFs  = faultPair | faultA | faultB;
        wantRst = (faultPair & state.settings[fim_pkg::IMP_PAIR_BIT])
                | (faultA & state.settings[fim_pkg::IMP_A_BIT])
                | (faultB & state.settings[fim_pkg::IMP_B_BIT]);
    end

    assign lockedWrite = regWr && regAddr == fim_pkg::REG_SETTINGS && state.phase == fim_pkg::FIM_PH_RUN;

    always_comb
    begin
        next_state = state;
        // settings only change in init phase; later writes are dropped and flagged
        if (regWr && regAddr == fim_pkg::REG_SETTINGS && state.phase == fim_pkg::FIM_PH_INIT)
            next_state.settings = regWdata[7:0];
        // phase closes once and only reset reopens it
        if (regWr && regAddr == fim_pkg::REG_PHASE && regWdata[0])
            next_state.phase = fim_pkg::FIM_PH_RUN;
        if (regWr && regAddr == fim_pkg::REG_MASK)
            next_state.mask = regWdata[3:0];
        if (regWr && regAddr == fim_pkg::REG_STATUS)
            next_state.status = state.status & ~regWdata[3:0];
        // set wins over clear
        next_state.status[fim_pkg::ST_PAIR] = next_state.status[fim_pkg::ST_PAIR] | faultPair;
        next_state.status[fim_pkg::ST_A]    = next_state.status[fim_pkg::ST_A] | faultA;
        next_state.status[fim_pkg::ST_B]    = next_state.status[fim_pkg::ST_B] | faultB;
        next_state.status[fim_pkg::ST_LOCK] = next_state.status[fim_pkg::ST_LOCK] | lockedWrite;
        next_state.rdata = 32'h0000_0000;
        if (regRd)
        begin
            unique case (regAddr)
                fim_pkg::REG_SETTINGS: next_state.rdata = {24'h00_0000, state.settings};
                fim_pkg::REG_PHASE:    next_state.rdata = {31'h0000_0000, state.phase};
                fim_pkg::REG_STATUS:   next_state.rdata = {28'h000_0000, state.status};
                fim_pkg::REG_MASK:     next_state.rdata = {28'h000_0000, state.mask};
                fim_pkg::REG_LEVELS:   next_state.rdata = {30'h0000_0000, inB, inA};
                default:               next_state.rdata = 32'h0000_0000;
            endcase
        end
        next_state.failsafeN = ~wantFs;
        next_state.resetN    = ~wantRst;
        next_state.irq       = |(next_state.status & next_state.mask);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state           <= '0;
            state.settings  <= fim_pkg::SETTINGS_RESET;
            state.phase     <= fim_pkg::FIM_PH_INIT;
            state.mask      <= fim_pkg::MASK_RESET;
            state.failsafeN <= 1'b1;
            state.resetN    <= 1'b1;
        end
        else
            state <= next_state;
    end

    assign regRdata        = state.rdata;
    assign failsafeOutputN = state.failsafeN;
    assign resetOutputN    = state.resetN;
    assign irq             = state.irq;

    // pin levels two edges later reach the outputs one edge after that
    property p_pair_pol0;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && !state.settings[fim_pkg::POL_PAIR_BIT] && (!inA || inB)) |=> !failsafeOutputN;
    endproperty
    a_pair_pol0: assert property (p_pair_pol0) else $error("pair fault pol0 missed");

    property p_pair_pol1;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && state.settings[fim_pkg::POL_PAIR_BIT] && (inA || !inB)) |=> !failsafeOutputN;
    endproperty
    a_pair_pol1: assert property (p_pair_pol1) else $error("pair fault pol1 missed");

    property p_pair_impact;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && faultPair) |=> (resetOutputN == !$past(state.settings[fim_pkg::IMP_PAIR_BIT]));
    endproperty
    a_pair_impact: assert property (p_pair_impact) else $error("pair impact wrong");

    property p_off_quiet;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_OFF) [*2] |-> failsafeOutputN && resetOutputN;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("monitoring off but output asserted");

    property p_a_indep;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg[1] && inA == state.settings[fim_pkg::POL_A_BIT]) |=> !failsafeOutputN;
    endproperty
    a_a_indep: assert property (p_a_indep) else $error("input a fault missed");

    property p_b_indep;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_INDEP && inB == state.settings[fim_pkg::POL_B_BIT]) |=> !failsafeOutputN;
    endproperty
    a_b_indep: assert property (p_b_indep) else $error("input b fault missed");

    property p_b_ignored;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_AONLY && inA != state.settings[fim_pkg::POL_A_BIT]) |=> failsafeOutputN;
    endproperty
    a_b_ignored: assert property (p_b_ignored) else $error("input b not ignored");

    property p_a_impact;
        @(posedge clk_sys) disable iff (!nrst)
        (faultA && !faultB && !state.settings[fim_pkg::IMP_A_BIT]) |=> resetOutputN && !failsafeOutputN;
    endproperty
    a_a_impact: assert property (p_a_impact) else $error("input a impact wrong");

    property p_b_impact;
        @(posedge clk_sys) disable iff (!nrst)
        (faultB && state.settings[fim_pkg::IMP_B_BIT]) |=> !resetOutputN;
    endproperty
    a_b_impact: assert property (p_b_impact) else $error("input b impact wrong");

    property p_lock;
        @(posedge clk_sys) disable iff (!nrst)
        (state.phase == fim_pkg::FIM_PH_RUN && regWr && regAddr == fim_pkg::REG_SETTINGS) |=> $stable(state.settings);
    endproperty
    a_lock: assert property (p_lock) else $error("settings changed after init");

    // synchroniser clears on reset, so only compare once two clean edges have passed
    property p_sync_delay;
        @(posedge clk_sys) disable iff (!nrst)
        ($past(nrst, 1) && $past(nrst, 2)) |-> (syncIn == $past({faultInputB, faultInputA}, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync path wrong");

    // each mode raises only its own fault terms
    property p_off_silent;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_OFF) |-> !faultPair && !faultA && !faultB;
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("fault raised while monitoring off");

    property p_pair_only;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR) |-> !faultA && !faultB;
    endproperty
    a_pair_only: assert property (p_pair_only) else $error("single input fault in pair mode");

    property p_indep_nopair;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_INDEP) |-> !faultPair;
    endproperty
    a_indep_nopair: assert property (p_indep_nopair) else $error("pair fault in independent mode");

    property p_aonly_b;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_AONLY) |-> !faultB && !faultPair;
    endproperty
    a_aonly_b: assert property (p_aonly_b) else $error("input b fault while a only");

    property p_a_alone;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_INDEP && inA == state.settings[fim_pkg::POL_A_BIT]) |-> faultA;
    endproperty
    a_a_alone: assert property (p_a_alone) else $error("input a fault not seen alone");

    property p_b_alone;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_INDEP && inB == state.settings[fim_pkg::POL_B_BIT]) |-> faultB;
    endproperty
    a_b_alone: assert property (p_b_alone) else $error("input b fault not seen alone");

    // healthy levels must never trip the outputs
    property p_pair_ok0;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && !state.settings[fim_pkg::POL_PAIR_BIT] && inA && !inB)
            |=> failsafeOutputN && resetOutputN;
    endproperty
    a_pair_ok0: assert property (p_pair_ok0) else $error("healthy pair pol0 tripped");

    property p_pair_ok1;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && state.settings[fim_pkg::POL_PAIR_BIT] && !inA && inB)
            |=> failsafeOutputN && resetOutputN;
    endproperty
    a_pair_ok1: assert property (p_pair_ok1) else $error("healthy pair pol1 tripped");

    property p_indep_quiet;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_INDEP && inA != state.settings[fim_pkg::POL_A_BIT]
            && inB != state.settings[fim_pkg::POL_B_BIT]) |=> failsafeOutputN && resetOutputN;
    endproperty
    a_indep_quiet: assert property (p_indep_quiet) else $error("healthy inputs tripped");

    // reset output never leaves without the fail-safe beside it
    property p_rst_with_fs;
        @(posedge clk_sys) disable iff (!nrst)
        !resetOutputN |-> !failsafeOutputN;
    endproperty
    a_rst_with_fs: assert property (p_rst_with_fs) else $error("reset out without failsafe");

    property p_pair_impact0;
        @(posedge clk_sys) disable iff (!nrst)
        (cfg == fim_pkg::FIM_CFG_PAIR && faultPair && !state.settings[fim_pkg::IMP_PAIR_BIT]) |=> resetOutputN;
    endproperty
    a_pair_impact0: assert property (p_pair_impact0) else $error("pair impact 0 drove reset");

    property p_a_impact1;
        @(posedge clk_sys) disable iff (!nrst)
        (faultA && state.settings[fim_pkg::IMP_A_BIT]) |=> !resetOutputN && !failsafeOutputN;
    endproperty
    a_a_impact1: assert property (p_a_impact1) else $error("input a impact 1 wrong");

    property p_b_impact0;
        @(posedge clk_sys) disable iff (!nrst)
        (faultB && !faultA && !state.settings[fim_pkg::IMP_B_BIT]) |=> resetOutputN && !failsafeOutputN;
    endproperty
    a_b_impact0: assert property (p_b_impact0) else $error("input b impact 0 wrong");

    // sticky status: a fault in the cycle of a clear still lands
    property p_status_pair;
        @(posedge clk_sys) disable iff (!nrst)
        faultPair |=> state.status[fim_pkg::ST_PAIR];
    endproperty
    a_status_pair: assert property (p_status_pair) else $error("pair fault not latched");

    property p_status_b;
        @(posedge clk_sys) disable iff (!nrst)
        faultB |=> state.status[fim_pkg::ST_B];
    endproperty
    a_status_b: assert property (p_status_b) else $error("input b fault not latched");

    // settings open only in init, restored by reset; the phase moves one way
    property p_init_write;
        @(posedge clk_sys) disable iff (!nrst)
        (state.phase == fim_pkg::FIM_PH_INIT && regWr && regAddr == fim_pkg::REG_SETTINGS)
            |=> (state.settings == $past(regWdata[7:0]));
    endproperty
    a_init_write: assert property (p_init_write) else $error("init write not taken");

    property p_lock_flag;
        @(posedge clk_sys) disable iff (!nrst)
        lockedWrite |=> state.status[fim_pkg::ST_LOCK];
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("locked write not flagged");

    property p_phase_oneway;
        @(posedge clk_sys) disable iff (!nrst)
        (state.phase == fim_pkg::FIM_PH_RUN) |=> (state.phase == fim_pkg::FIM_PH_RUN);
    endproperty
    a_phase_oneway: assert property (p_phase_oneway) else $error("init phase reopened");

    property p_reset_defaults;
        @(posedge clk_sys)
        (nrst && !$past(nrst)) |-> (state.settings == fim_pkg::SETTINGS_RESET
            && state.phase == fim_pkg::FIM_PH_INIT && state.mask == fim_pkg::MASK_RESET);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored");
endmodule

// [shared/fim_pkg.sv]
package fim_pkg;
    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] REG_SETTINGS = 8'h00;
    localparam logic [7:0] REG_PHASE    = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_MASK     = 8'h0C;
    localparam logic [7:0] REG_LEVELS   = 8'h10;

    // settings field positions
    localparam int CFG_LSB      = 0;
    localparam int POL_PAIR_BIT = 2;
    localparam int IMP_PAIR_BIT = 3;
    localparam int POL_A_BIT    = 4;
    localparam int POL_B_BIT    = 5;
    localparam int IMP_A_BIT    = 6;
    localparam int IMP_B_BIT    = 7;

    // status bit positions
    localparam int ST_PAIR = 0;
    localparam int ST_A    = 1;
    localparam int ST_B    = 2;
    localparam int ST_LOCK = 3;

    // settings reset value: cfg 01, pair pol 0, pair impact 1, a/b pol 0, a/b impact 1
    localparam logic [7:0] SETTINGS_RESET = 8'hC9;
    localparam logic [3:0] MASK_RESET     = 4'h0;

    typedef enum logic [1:0] {
        FIM_CFG_OFF   = 2'b00,
        FIM_CFG_PAIR  = 2'b01,
        FIM_CFG_INDEP = 2'b10,
        FIM_CFG_AONLY = 2'b11
    } fim_cfg_e;

    typedef enum logic [0:0] {
        FIM_PH_INIT = 1'b0,
        FIM_PH_RUN  = 1'b1
    } fim_phase_e;
endpackage

// [logic/fim_sync.sv]
`timescale 1ns/1ps
module fim_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } fim_sync_s;

    fim_sync_s state;
    fim_sync_s next_state;

    // stage1 feeds only stage2
    always_comb
    begin
        next_state.stage1 = asyncIn;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            state <= '0;
        else
            state <= next_state;
    end

    assign syncOut = state.stage2;
endmodule

// [dv/fim_mcu_model.sv]
`timescale 1ns/1ps
module fim_mcu_model (
    input  wire logic clk_sys,
    input  wire logic pairMode,
    input  wire logic levelA,
    input  wire logic levelB,
    output logic      faultInputA,
    output logic      faultInputB
);
    // healthy pair levels at time zero, before any request
    initial faultInputA = 1'b1;
    initial faultInputB = 1'b0;

    // pins move just after an edge; in pair mode b is always the complement of a
    always @(posedge clk_sys)
    begin
        faultInputA <= levelA;
        faultInputB <= pairMode ? ~levelA : levelB;
    end
endmodule

// [dv/test_mcu_fault_input_monitor.sv]
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("Error t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module test_mcu_fault_input_monitor;
    logic        clk_sys     = 1'b0;
    logic        nrst        = 1'b0;
    logic [7:0]  regAddr     = 8'h00;
    logic [31:0] regWdata    = 32'h0;
    logic        regWr       = 1'b0;
    logic        regRd       = 1'b0;
    logic        pairMode    = 1'b1;
    logic        levelA      = 1'b1;
    logic        levelB      = 1'b0;
    logic [31:0] regRdata;
    logic        failsafeOutputN;
    logic        resetOutputN;
    logic        irq;
    logic        faultInputA;
    logic        faultInputB;
    int          n_fail      = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          seed        = 32'h5a42;
    logic [7:0]  settings;
    logic [3:0]  mask;
    logic [2:0]  faults;
    // hand-picked corners first: default, off, pair inverted, indep all high, indep mixed, a only
    logic [7:0]  corner [6]  = '{8'hC9, 8'h00, 8'h05, 8'hFE, 8'h32, 8'h8B};

    always #20 clk_sys = ~clk_sys;

    fim_mcu_model u_mcu (.clk_sys(clk_sys), .pairMode(pairMode), .levelA(levelA), .levelB(levelB),
                         .faultInputA(faultInputA), .faultInputB(faultInputB));

    fim_monitor dut_u (.clk_sys(clk_sys), .nrst(nrst), .faultInputA(faultInputA), .faultInputB(faultInputB),
                       .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
                       .regRdata(regRdata), .failsafeOutputN(failsafeOutputN), .resetOutputN(resetOutputN),
                       .irq(irq));

    // {b fault, a fault, pair fault} as status should show it
    function automatic logic [2:0] faultVec(input logic [7:0] s, input logic a, input logic b);
        logic fa;
        logic fb;
        fa = s[fim_pkg::POL_A_BIT] ? a : ~a;
        fb = s[fim_pkg::POL_B_BIT] ? b : ~b;
        case (s[1:0])
            2'b01:   return {2'b00, s[fim_pkg::POL_PAIR_BIT] ? (a | ~b) : (~a | b)};
            2'b10:   return {fb, fa, 1'b0};
            2'b11:   return {1'b0, fa, 1'b0};
            default: return 3'b000;
        endcase
    endfunction

    function automatic logic [1:0] expOut(input logic [7:0] s, input logic [2:0] f);
        logic rst;
        rst = (f[0] & s[fim_pkg::IMP_PAIR_BIT]) | (f[1] & s[fim_pkg::IMP_A_BIT]) | (f[2] & s[fim_pkg::IMP_B_BIT]);
        return {~|f, ~rst};
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1 d = regRdata;
        `CHK(d, exp)
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (n) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        // 48 passes of about 31 cycles each; generous ceiling
        if (cycles == 20000)
        begin
            n_fail++;
            print_verdict;
        end
    end

    initial
    begin
        for (int i = 0; i < 48; i++)
        begin
            do_reset(i == 0 ? 20 : 2);
            chk_rd(fim_pkg::REG_SETTINGS, 32'h0000_00C9);
            settings = (i < 6) ? corner[i] : 8'($random(seed));
            mask     = 4'($random(seed));
            wr(fim_pkg::REG_SETTINGS, {24'h0, settings});
            wr(fim_pkg::REG_MASK, {28'h0, mask});
            // every third pass lets b run free in pair mode, as a stuck or shorted pin would
            pairMode <= (settings[1:0] == 2'b01) && (i % 3 != 2);
            levelA   <= 1'($random(seed));
            levelB   <= 1'($random(seed));
            // model edge, two sync stages, output register, then margin
            repeat (6) @(posedge clk_sys);
            #1 faults = faultVec(settings, faultInputA, faultInputB);
            `CHK({failsafeOutputN, resetOutputN}, expOut(settings, faults))
            wr(fim_pkg::REG_STATUS, 32'h0000_000F);
            chk_rd(fim_pkg::REG_STATUS, {29'h0, faults});
            `CHK(irq, |(faults & mask[2:0]))
            chk_rd(fim_pkg::REG_LEVELS, {30'h0, faultInputB, faultInputA});
            wr(fim_pkg::REG_PHASE, 32'h0000_0001);
            wr(fim_pkg::REG_SETTINGS, {24'h0, ~settings});
            chk_rd(fim_pkg::REG_SETTINGS, {24'h0, settings});
            chk_rd(fim_pkg::REG_STATUS, {28'h0, 1'b1, faults});
            chk_rd(8'h20, 32'h0);
            `CHK({failsafeOutputN, resetOutputN}, expOut(settings, faults))
            $display("test %0d done settings %h pins %b%b", i, settings, faultInputA, faultInputB);
        end
        print_verdict;
    end
endmodule
